// File: sisel_pkg.sv
// sisel_pkg: constants and types of the serial input pin select block
package sisel_pkg;

  // ==========================================================================
  // register map, byte addresses on the AHB-Lite bus
  // ==========================================================================
  localparam logic [11:0] SPI1_CLOCK_DATA_OFFSET    = 12'h000;
  localparam logic [11:0] UART3_HS_SPI1_SS_OFFSET   = 12'h004;
  localparam logic [11:0] SPI2_CLOCK_DATA_OFFSET    = 12'h008;
  localparam logic [11:0] SPI2_SLAVE_SELECT_OFFSET  = 12'h00C;
  localparam logic [11:0] UART4_HS_RECEIVE_OFFSET   = 12'h010;
  localparam logic [11:0] SPI3_CLOCK_DATA_OFFSET    = 12'h014;
  localparam int          ADDR_DECODE_W             = 12;

  // register index after decode
  localparam logic [2:0]  REG_SPI1_CLOCK_DATA       = 3'h0;
  localparam logic [2:0]  REG_UART3_HS_SPI1_SS      = 3'h1;
  localparam logic [2:0]  REG_SPI2_CLOCK_DATA       = 3'h2;
  localparam logic [2:0]  REG_SPI2_SLAVE_SELECT     = 3'h3;
  localparam logic [2:0]  REG_UART4_HS_RECEIVE      = 3'h4;
  localparam logic [2:0]  REG_SPI3_CLOCK_DATA       = 3'h5;
  localparam logic [2:0]  REG_NONE                  = 3'h7;

  // ==========================================================================
  // field layout
  // ==========================================================================
  localparam int          SEL_W                     = 6;
  localparam int          HI_FIELD_LSB              = 8;
  localparam int          LO_FIELD_LSB              = 0;
  localparam int          REG_W                     = 16;
  localparam logic [5:0]  SEL_RESET                 = 6'h3F;
  localparam int          NUM_SEL                   = 11;

  // selector index, also the bit index of the peripheral input vector
  localparam int          SEL_SPI1_CLOCK            = 0;
  localparam int          SEL_SPI1_DATA             = 1;
  localparam int          SEL_UART3_HANDSHAKE       = 2;
  localparam int          SEL_SPI1_SLAVE_SELECT     = 3;
  localparam int          SEL_SPI2_CLOCK            = 4;
  localparam int          SEL_SPI2_DATA             = 5;
  localparam int          SEL_SPI2_SLAVE_SELECT     = 6;
  localparam int          SEL_UART4_HANDSHAKE       = 7;
  localparam int          SEL_UART4_RECEIVE         = 8;
  localparam int          SEL_SPI3_CLOCK            = 9;
  localparam int          SEL_SPI3_DATA             = 10;

  // ==========================================================================
  // pins: bidirectional pins first, input-only pins numbered after them
  // ==========================================================================
  localparam int          BIDIR_PIN_COUNT           = 32;
  localparam int          INPUT_ONLY_PIN_COUNT      = 16;
  localparam int          PIN_COUNT                 = 48;
  localparam logic [5:0]  PIN_LIMIT                 = 6'h30;
  localparam logic        INACTIVE_LEVEL            = 1'b1;

  // ==========================================================================
  // AHB-Lite encodings
  // ==========================================================================
  localparam logic [2:0]  HSIZE_BYTE                = 3'h0;
  localparam logic [2:0]  HSIZE_HALF                = 3'h1;
  localparam logic        HRESP_OKAY                = 1'b0;

  typedef struct packed {
    logic spi3_data_input;
    logic spi3_clock_input;
    logic uart4_receive_input;
    logic uart4_clear_to_send_input;
    logic spi2_slave_select_input;
    logic spi2_data_input;
    logic spi2_clock_input;
    logic spi1_slave_select_input;
    logic uart3_clear_to_send_input;
    logic spi1_data_input;
    logic spi1_clock_input;
  } sisel_periph_t;

  typedef struct packed {
    logic [NUM_SEL-1:0][SEL_W-1:0] sel;
    logic [PIN_COUNT-1:0]          pin_meta;
    logic [PIN_COUNT-1:0]          pin_sync;
    logic                          wr_pend;
    logic [2:0]                    wr_reg;
    logic                          wr_lo_en;
    logic                          wr_hi_en;
    logic [31:0]                   hrdata;
    logic                          hreadyout;
    logic                          hresp;
    sisel_periph_t                 periph;
  } sisel_state_t;

  localparam sisel_state_t STATE_RESET = '{
    sel       : {NUM_SEL{SEL_RESET}},
    pin_meta  : '0,
    pin_sync  : '0,
    wr_pend   : 1'b0,
    wr_reg    : REG_NONE,
    wr_lo_en  : 1'b0,
    wr_hi_en  : 1'b0,
    hrdata    : 32'h0000_0000,
    hreadyout : 1'b1,
    hresp     : HRESP_OKAY,
    periph    : {NUM_SEL{INACTIVE_LEVEL}}
  };

endpackage

// File: sisel_pin_mux.sv
// sisel_pin_mux: picks one synchronised pin by its six-bit number
`timescale 1ns/1ps
`default_nettype none

module sisel_pin_mux
(
  input  wire logic [sisel_pkg::PIN_COUNT-1:0] pins_i,
  input  wire logic [sisel_pkg::SEL_W-1:0]     selector_i,
  output logic                                 value_o
);

  // ==========================================================================
  // selection
  // ==========================================================================
  always_comb
  begin
    if (selector_i < sisel_pkg::PIN_LIMIT)
    begin
      value_o = pins_i[selector_i];
    end
    else
    begin
      value_o = sisel_pkg::INACTIVE_LEVEL;
    end
  end

endmodule

`default_nettype wire

// File: sisel_top.sv
// sisel_top: serial peripheral input pin select with AHB-Lite registers
//
// Behaviour
// - spi1 clock input comes from pin named by bits 13:8 of spi1 register.
// - spi1 data input comes from pin named by bits 5:0 of spi1 register.
// - uart3 clear-to-send comes from pin named by bits 13:8, second reg.
// - spi1 slave select comes from pin named by bits 5:0, second reg.
// - spi2 clock input comes from pin named by bits 13:8 of spi2 register.
// - spi2 data input comes from pin named by bits 5:0 of spi2 register.
// - spi2 slave select uses bits 5:0 of own register; 15:6 unimplemented.
// - uart4 clear-to-send comes from pin named by bits 13:8, uart4 reg.
// - uart4 receive comes from pin named by bits 5:0 of uart4 register.
// - spi3 clock input comes from pin named by bits 13:8, spi3 register.
// - spi3 data input comes from pin named by bits 5:0, spi3 register.
// - unimplemented register bits always read zero.
// - reset sets every selector to all ones.
// - a selector may name a bidirectional or an input-only pin.
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module sisel_top
(
  input  wire logic                                      core_clk_i,
  input  wire logic                                      reset_n_i,
  input  wire logic                                      hsel_i,
  input  wire logic [31:0]                               haddr_i,
  input  wire logic [1:0]                                htrans_i,
  input  wire logic                                      hwrite_i,
  input  wire logic [2:0]                                hsize_i,
  input  wire logic                                      hready_i,
  input  wire logic [31:0]                               hwdata_i,
  output logic      [31:0]                               hrdata_o,
  output logic                                           hreadyout_o,
  output logic                                           hresp_o,
  input  wire logic [sisel_pkg::BIDIR_PIN_COUNT-1:0]     remappable_pin_i,
  input  wire logic [sisel_pkg::INPUT_ONLY_PIN_COUNT-1:0] remappable_input_only_pin_i,
  output var sisel_pkg::sisel_periph_t                   serial_inputs_o
);

  sisel_pkg::sisel_state_t          cur;
  sisel_pkg::sisel_state_t          next_cur;
  logic [sisel_pkg::NUM_SEL-1:0]    mux_out;
  logic [2:0]                       addr_reg;
  logic                             lane_lo;
  logic                             lane_hi;

  // ==========================================================================
  // address decode
  // ==========================================================================
  function automatic logic [2:0] decode_reg
  (
    input logic [31:0] addr
  );
    logic [2:0] idx;
    idx = sisel_pkg::REG_NONE;
    if (addr[31:sisel_pkg::ADDR_DECODE_W] == '0)
    begin
      case (addr[sisel_pkg::ADDR_DECODE_W-1:0])
        sisel_pkg::SPI1_CLOCK_DATA_OFFSET:
          idx = sisel_pkg::REG_SPI1_CLOCK_DATA;
        sisel_pkg::UART3_HS_SPI1_SS_OFFSET:
          idx = sisel_pkg::REG_UART3_HS_SPI1_SS;
        sisel_pkg::SPI2_CLOCK_DATA_OFFSET:
          idx = sisel_pkg::REG_SPI2_CLOCK_DATA;
        sisel_pkg::SPI2_SLAVE_SELECT_OFFSET:
          idx = sisel_pkg::REG_SPI2_SLAVE_SELECT;
        sisel_pkg::UART4_HS_RECEIVE_OFFSET:
          idx = sisel_pkg::REG_UART4_HS_RECEIVE;
        sisel_pkg::SPI3_CLOCK_DATA_OFFSET:
          idx = sisel_pkg::REG_SPI3_CLOCK_DATA;
        default:
          idx = sisel_pkg::REG_NONE;
      endcase
    end
    return idx;
  endfunction

  // ==========================================================================
  // register to selector mapping; -1 marks an absent field
  // ==========================================================================
  function automatic int hi_sel
  (
    input logic [2:0] r
  );
    int s;
    s = -1;
    case (r)
      sisel_pkg::REG_SPI1_CLOCK_DATA:  s = sisel_pkg::SEL_SPI1_CLOCK;
      sisel_pkg::REG_UART3_HS_SPI1_SS: s = sisel_pkg::SEL_UART3_HANDSHAKE;
      sisel_pkg::REG_SPI2_CLOCK_DATA:  s = sisel_pkg::SEL_SPI2_CLOCK;
      sisel_pkg::REG_UART4_HS_RECEIVE: s = sisel_pkg::SEL_UART4_HANDSHAKE;
      sisel_pkg::REG_SPI3_CLOCK_DATA:  s = sisel_pkg::SEL_SPI3_CLOCK;
      default:                         s = -1;
    endcase
    return s;
  endfunction

  function automatic int lo_sel
  (
    input logic [2:0] r
  );
    int s;
    s = -1;
    case (r)
      sisel_pkg::REG_SPI1_CLOCK_DATA:   s = sisel_pkg::SEL_SPI1_DATA;
      sisel_pkg::REG_UART3_HS_SPI1_SS:  s = sisel_pkg::SEL_SPI1_SLAVE_SELECT;
      sisel_pkg::REG_SPI2_CLOCK_DATA:   s = sisel_pkg::SEL_SPI2_DATA;
      sisel_pkg::REG_SPI2_SLAVE_SELECT: s = sisel_pkg::SEL_SPI2_SLAVE_SELECT;
      sisel_pkg::REG_UART4_HS_RECEIVE:  s = sisel_pkg::SEL_UART4_RECEIVE;
      sisel_pkg::REG_SPI3_CLOCK_DATA:   s = sisel_pkg::SEL_SPI3_DATA;
      default:                          s = -1;
    endcase
    return s;
  endfunction

  // read image: only selector bits, all else zero
  function automatic logic [31:0] read_image
  (
    input logic [sisel_pkg::NUM_SEL-1:0][sisel_pkg::SEL_W-1:0] sel,
    input logic [2:0]                                          r
  );
    logic [31:0] img;
    int          h;
    int          l;
    img = 32'h0000_0000;
    h   = hi_sel(r);
    l   = lo_sel(r);
    if (h >= 0)
    begin
      img[sisel_pkg::HI_FIELD_LSB +: sisel_pkg::SEL_W] = sel[h];
    end
    if (l >= 0)
    begin
      img[sisel_pkg::LO_FIELD_LSB +: sisel_pkg::SEL_W] = sel[l];
    end
    return img;
  endfunction

  // ==========================================================================
  // byte lanes of the address phase; register bits live in lanes 0 and 1
  // ==========================================================================
  assign addr_reg = decode_reg(haddr_i);

  always_comb
  begin
    lane_lo = 1'b1;
    lane_hi = 1'b1;
    if (hsize_i == sisel_pkg::HSIZE_BYTE)
    begin
      lane_lo = (haddr_i[1:0] == 2'h0);
      lane_hi = (haddr_i[1:0] == 2'h1);
    end
    else if (hsize_i == sisel_pkg::HSIZE_HALF)
    begin
      lane_lo = ~haddr_i[1];
      lane_hi = ~haddr_i[1];
    end
  end

  // ==========================================================================
  // one selector multiplexer per peripheral input
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < sisel_pkg::NUM_SEL; g++)
    begin : g_mux
      sisel_pin_mux u_mux
      (
        .pins_i     (cur.pin_sync),
        .selector_i (cur.sel[g]),
        .value_o    (mux_out[g])
      );
    end
  endgenerate

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    int h;
    int l;
    next_cur = cur;
    h        = hi_sel(cur.wr_reg);
    l        = lo_sel(cur.wr_reg);

    // pins pass two flops before the multiplexers see them
    next_cur.pin_meta = {remappable_input_only_pin_i, remappable_pin_i};
    next_cur.pin_sync = cur.pin_meta;

    // data phase of a write stores the selector fields
    if (cur.wr_pend)
    begin
      if (cur.wr_hi_en && (h >= 0))
      begin
        next_cur.sel[h] =
          hwdata_i[sisel_pkg::HI_FIELD_LSB +: sisel_pkg::SEL_W];
      end
      if (cur.wr_lo_en && (l >= 0))
      begin
        next_cur.sel[l] =
          hwdata_i[sisel_pkg::LO_FIELD_LSB +: sisel_pkg::SEL_W];
      end
    end

    // address phase; read data built from the updated selectors
    next_cur.wr_pend  = 1'b0;
    next_cur.wr_reg   = sisel_pkg::REG_NONE;
    next_cur.wr_lo_en = 1'b0;
    next_cur.wr_hi_en = 1'b0;
    next_cur.hrdata   = 32'h0000_0000;
    if (hsel_i && hready_i && htrans_i[1])
    begin
      if (hwrite_i)
      begin
        next_cur.wr_pend  = (addr_reg != sisel_pkg::REG_NONE);
        next_cur.wr_reg   = addr_reg;
        next_cur.wr_lo_en = lane_lo;
        next_cur.wr_hi_en = lane_hi;
      end
      else
      begin
        next_cur.hrdata = read_image(next_cur.sel, addr_reg);
      end
    end
    next_cur.hreadyout = 1'b1;
    // every transfer is answered at once and never refused
    next_cur.hresp     = sisel_pkg::HRESP_OKAY;

    // routing of each peripheral input
    next_cur.periph.spi1_clock_input =
      mux_out[sisel_pkg::SEL_SPI1_CLOCK];
    next_cur.periph.spi1_data_input =
      mux_out[sisel_pkg::SEL_SPI1_DATA];
    next_cur.periph.uart3_clear_to_send_input =
      mux_out[sisel_pkg::SEL_UART3_HANDSHAKE];
    next_cur.periph.spi1_slave_select_input =
      mux_out[sisel_pkg::SEL_SPI1_SLAVE_SELECT];
    next_cur.periph.spi2_clock_input =
      mux_out[sisel_pkg::SEL_SPI2_CLOCK];
    next_cur.periph.spi2_data_input =
      mux_out[sisel_pkg::SEL_SPI2_DATA];
    next_cur.periph.spi2_slave_select_input =
      mux_out[sisel_pkg::SEL_SPI2_SLAVE_SELECT];
    next_cur.periph.uart4_clear_to_send_input =
      mux_out[sisel_pkg::SEL_UART4_HANDSHAKE];
    next_cur.periph.uart4_receive_input =
      mux_out[sisel_pkg::SEL_UART4_RECEIVE];
    next_cur.periph.spi3_clock_input =
      mux_out[sisel_pkg::SEL_SPI3_CLOCK];
    next_cur.periph.spi3_data_input =
      mux_out[sisel_pkg::SEL_SPI3_DATA];
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      cur <= sisel_pkg::STATE_RESET;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign hrdata_o        = cur.hrdata;
  assign hreadyout_o     = cur.hreadyout;
  assign hresp_o         = cur.hresp;
  assign serial_inputs_o = cur.periph;

endmodule

`default_nettype wire

// File: sisel_monitor.sv
// sisel_monitor: port-level checks of the serial input pin select block
`timescale 1ns/1ps
`default_nettype none

module sisel_monitor
(
  input wire logic                   core_clk_i,
  input wire logic                   reset_n_i,
  input wire logic                   hsel_i,
  input wire logic [31:0]            haddr_i,
  input wire logic [1:0]             htrans_i,
  input wire logic                   hwrite_i,
  input wire logic [2:0]             hsize_i,
  input wire logic                   hready_i,
  input wire logic [31:0]            hwdata_i,
  input wire logic [31:0]            hrdata_o,
  input wire logic                   hreadyout_o,
  input wire logic                   hresp_o,
  input wire logic [31:0]            remappable_pin_i,
  input wire logic [15:0]            remappable_input_only_pin_i,
  input wire sisel_pkg::sisel_periph_t serial_inputs_o
);
  // ==========================================================================
  // bus phase tracking
  // ==========================================================================
  logic        req;
  logic        rd_ph;
  logic        wr_ph;
  logic        wmap;
  logic        any_wr;
  logic [11:0] wa;
  logic [15:0] mk;

  assign req = hsel_i & hready_i & htrans_i[1];
  assign mk  = (wa == 12'h00C) ? 16'h003F : 16'h3F3F;

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      rd_ph  <= 1'b0;
      wr_ph  <= 1'b0;
      wmap   <= 1'b0;
      any_wr <= 1'b0;
      wa     <= 12'h000;
    end
    else
    begin
      rd_ph <= req & ~hwrite_i;
      wr_ph <= req & hwrite_i;
      wmap  <= req & hwrite_i & (haddr_i[31:12] == 20'h00000)
               & (haddr_i[11:0] <= 12'h014) & (haddr_i[1:0] == 2'h0)
               & (hsize_i == 3'h2);
      if (req)
        wa <= haddr_i[11:0];
      if (wr_ph)
        any_wr <= 1'b1;
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence wr_done_s;
    wmap;
  endsequence

  sequence rd_same_s;
    req && !hwrite_i && haddr_i[11:0] == wa && haddr_i[31:12] == 20'h00000;
  endsequence

  sequence quiet_s;
    $stable(remappable_pin_i) && $stable(remappable_input_only_pin_i)
      && !wr_ph;
  endsequence

  hresp_okay_a: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  ready_high_a: assert property (hreadyout_o == 1'b1)
    else $error("ready dropped");
  idle_zero_a: assert property (!rd_ph |-> hrdata_o == 32'h00000000)
    else $error("read data outside read phase");
  unimpl_zero_a: assert property
    (rd_ph |-> (hrdata_o & 32'hFFFFC0C0) == 32'h00000000)
    else $error("unimplemented bits read nonzero");
  ss2_upper_a: assert property
    (rd_ph && wa == sisel_pkg::SPI2_SLAVE_SELECT_OFFSET
      |-> hrdata_o[15:6] == 10'h000)
    else $error("slave select upper bits nonzero");
  reset_sel_a: assert property
    (!any_wr |-> serial_inputs_o == 11'h7FF)
    else $error("input active with reset selectors");
  read_back_a: assert property
    (wr_done_s ##1 rd_same_s |=> hrdata_o[15:0] ==
      ($past(hwdata_i[15:0], 2) & mk))
    else $error("read back differs from write");
  route_stable_a: assert property
    (quiet_s [*4] |-> $stable(serial_inputs_o))
    else $error("input moved with pins and selectors still");
endmodule

bind sisel_top sisel_monitor u_mon (.core_clk_i, .reset_n_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hready_i, .hwdata_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .remappable_pin_i,
  .remappable_input_only_pin_i, .serial_inputs_o);

`default_nettype wire

// File: sisel_pin_model.sv
// sisel_pin_model: remappable pins driven from a bench level pattern
`timescale 1ns/1ps
`default_nettype none

module sisel_pin_model
(
  input  wire logic        core_clk_i,
  input  wire logic [47:0] level_i,
  output logic      [31:0] remappable_pin_o,
  output logic      [15:0] remappable_input_only_pin_o
);
  // pins move just after an edge, bidirectional and input-only on the same edge
  always @(posedge core_clk_i)
  begin
    remappable_pin_o <= level_i[31:0];
    remappable_input_only_pin_o <= level_i[47:32];
  end
endmodule

`default_nettype wire

// File: serial_input_pin_select_tb_top.sv
// serial_input_pin_select_tb_top: self-checking bench of the pin select
`timescale 1ns/1ps
`default_nettype none

module serial_input_pin_select_tb_top;
  logic                      core_clk_i;
  logic                      reset_n_i;
  logic                      hsel_i;
  logic [31:0]               haddr_i;
  logic [1:0]                htrans_i;
  logic                      hwrite_i;
  logic [2:0]                hsize_i;
  wire logic                 hready_i;
  logic [31:0]               hwdata_i;
  logic [31:0]               hrdata_o;
  logic                      hreadyout_o;
  logic                      hresp_o;
  wire logic [31:0]          remappable_pin_i;
  wire logic [15:0]          remappable_input_only_pin_i;
  sisel_pkg::sisel_periph_t  serial_inputs_o;
  logic [47:0]               pat;
  logic [31:0]               rd;
  int                        n_fail;
  int                        tests_run;
  int                        cyc;

  assign hready_i = hreadyout_o;

  sisel_top DUT (.core_clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o,
    .hresp_o, .remappable_pin_i, .remappable_input_only_pin_i,
    .serial_inputs_o);

  sisel_pin_model PINS (.core_clk_i, .level_i(pat),
    .remappable_pin_o(remappable_pin_i),
    .remappable_input_only_pin_o(remappable_input_only_pin_i));

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_pin(input logic [10:0] e);
    tests_run++;
    if (serial_inputs_o !== e)
    begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, serial_inputs_o);
    end
  endtask

  task automatic bus(input logic w, input int r, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= 32'(r * 4);
    hwrite_i <= w;
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic do_reset();
    reset_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
  endtask

  task automatic print_verdict();
    $display("n_fail=%0d tests_run=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset();
    for (int r = 0; r < 6; r++)
    begin
      bus(1'b0, r, 32'h0);
      chk_reg((r == 3) ? 32'h003F : 32'h3F3F, rd);
    end
    bus(1'b0, 6, 32'h0);
    chk_reg(32'h0, rd);
    chk_pin(11'h7FF);
  endtask

  // selector k names pin 7+4k: reaches pin 31 and input-only pin 47
  task automatic t_route();
    int          hi_i[6] = '{0, 2, 4, 0, 7, 9};
    int          lo_i[6] = '{1, 3, 5, 6, 8, 10};
    logic [5:0]  h;
    logic [5:0]  l;
    logic [10:0] e;
    for (int r = 0; r < 6; r++)
    begin
      h = (r == 3) ? 6'h3F : 6'(7 + 4 * hi_i[r]);
      l = 6'(7 + 4 * lo_i[r]);
      bus(1'b1, r, 32'hFFFFC0C0 | {18'h0, h, 2'h0, l});
      bus(1'b0, r, 32'h0);
      chk_reg({18'h0, (r == 3) ? 6'h00 : h, 2'h0, l}, rd);
    end
    for (int p = 0; p < 2; p++)
    begin
      pat <= (p == 0) ? 48'h0F0FF0F00F0F : 48'hF0F00F0FF0F0;
      repeat (5) @(posedge core_clk_i);
      #1;
      for (int k = 0; k < 11; k++)
        e[k] = pat[7 + 4 * k];
      chk_pin(e);
      chk_pin(e);
    end
    pat <= 48'h0;
    for (int r = 0; r < 6; r++)
      bus(1'b1, r, 32'h00003030);
    repeat (5) @(posedge core_clk_i);
    #1;
    chk_pin(11'h7FF);
  endtask

  // ==========================================================================
  // main sequence and hang guard
  // ==========================================================================
  initial
  begin
    n_fail = 0;
    tests_run = 0;
    reset_n_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    pat = 48'h0;
    do_reset();
    t_reset();
    t_route();
    do_reset();
    t_reset();
    print_verdict();
  end

  initial
    cyc = 0;

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      print_verdict();
    end
  end
endmodule

`default_nettype wire
